// [pkg/alu_pkg.sv]
package alu_pkg;

    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int WIMM_W = 6;
    localparam int PAIR_W = 2;

    // Flag positions in the status byte
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ZERO   = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONES   = 8'hFF;
    localparam logic [DATA_W-1:0] BYTE_ONE    = 8'h01;
    localparam logic [DATA_W-1:0] OVF_INC     = 8'h80;
    localparam logic [DATA_W-1:0] OVF_DEC     = 8'h7F;

    // Cycle counts per operation class
    localparam int BYTE_OP_CYCLES = 1;
    localparam int WORD_OP_CYCLES = 2;

    typedef enum logic [4:0] {
        OP_SUM,
        OP_SUM_CARRY,
        OP_DIFF,
        OP_DIFF_IMM,
        OP_DIFF_BORROW,
        OP_DIFF_CARRY_IMM,
        OP_WORD_PLUS_IMM,
        OP_WORD_MINUS_IMM,
        OP_CONJ,
        OP_CONJ_IMM,
        OP_DISJ,
        OP_DISJ_IMM,
        OP_EXCL_DISJ,
        OP_BIT_SET_MASK,
        OP_BIT_CLEAR_MASK,
        OP_INVERT,
        OP_SIGN_FLIP,
        OP_PLUS_ONE,
        OP_MINUS_ONE,
        OP_ZERO_SIGN_TEST,
        OP_ZERO_REG,
        OP_ALL_ONES
    } op_t;

    typedef enum logic {
        ST_IDLE,
        ST_WORD_HI
    } state_t;

endpackage

// [pkg/byte_arith_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface byte_arith_if;
    import alu_pkg::*;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic              cin;
    logic              sub;
    logic [DATA_W-1:0] res;
    logic              cout;
    logic              half;
    logic              ovf;

    modport user (output a, output b, output cin, output sub,
                  input res, input cout, input half, input ovf);
    modport unit (input a, input b, input cin, input sub,
                  output res, output cout, output half, output ovf);
endinterface

`default_nettype wire

// [src/byte_arith.sv]
`timescale 1ns/1ps
`default_nettype none

module byte_arith
(
    byte_arith_if.unit bus
);
    import alu_pkg::*;

    logic [DATA_W:0] full;
    logic [4:0]      nib;

    ////////////////////////////////////////////////////////////////////////
    // Sum or difference with carry/borrow
    always_comb
    begin
        if (bus.sub)
        begin
            full = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cin};
            nib  = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, bus.cin};
        end
        else
        begin
            full = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin};
            nib  = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag terms
    assign bus.res  = full[DATA_W-1:0];
    assign bus.cout = full[DATA_W];
    assign bus.half = nib[4];
    assign bus.ovf  = bus.sub
                    ? ((bus.a[7] != bus.b[7]) && (full[7] != bus.a[7]))
                    : ((bus.a[7] == bus.b[7]) && (full[7] != bus.a[7]));

endmodule

`default_nettype wire

// [src/alu_core.sv]
`timescale 1ns/1ps
`default_nettype none

module alu_core
(
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    input  wire logic                   i_valid,
    input  wire alu_pkg::op_t           i_op,
    input  wire logic [alu_pkg::DATA_W-1:0] i_dest,
    input  wire logic [alu_pkg::DATA_W-1:0] i_src,
    input  wire logic [alu_pkg::DATA_W-1:0] i_imm,
    input  wire logic [alu_pkg::PAIR_W-1:0] i_pair_sel,
    input  wire logic [alu_pkg::DATA_W-1:0] i_pair_lo,
    input  wire logic [alu_pkg::DATA_W-1:0] i_pair_hi,
    output logic [alu_pkg::DATA_W-1:0]      o_result,
    output logic [alu_pkg::DATA_W-1:0]      o_result_hi,
    output logic                            o_write,
    output logic                            o_write_word,
    output logic [alu_pkg::PAIR_W-1:0]      o_pair_sel,
    output logic [alu_pkg::DATA_W-1:0]      o_flags,
    output logic                            o_busy
);
    import alu_pkg::*;

    byte_arith_if arith ();

    state_t              state_r;
    logic [DATA_W-1:0]   flags_r;
    logic [DATA_W-1:0]   flags_nxt;
    logic [DATA_W-1:0]   res_nxt;
    logic                wr_nxt;
    logic                logic_op;
    logic                arith_op;
    logic [DATA_W-1:0]   wlo_r;
    logic [DATA_W-1:0]   whi_r;
    logic [WIMM_W-1:0]   wimm_r;
    logic                wsub_r;
    logic [PAIR_W-1:0]   wpair_r;
    logic [WORD_W-1:0]   wres;
    logic [DATA_W-1:0]   wflags;
    logic                wvf;
    logic                wcf;
    logic                take;
    logic                word_req;

    logic [DATA_W-1:0]   result_r;
    logic [DATA_W-1:0]   result_hi_r;
    logic                write_r;
    logic                write_word_r;
    logic [PAIR_W-1:0]   pair_r;

    byte_arith u_arith
    (
        .bus (arith.unit)
    );

    assign take     = i_valid && (state_r == ST_IDLE);
    assign word_req = (i_op == OP_WORD_PLUS_IMM) || (i_op == OP_WORD_MINUS_IMM);

    ////////////////////////////////////////////////////////////////////////
    // Operand steering into the byte adder
    always_comb
    begin
        arith.a   = i_dest;
        arith.b   = i_src;
        arith.cin = 1'b0;
        arith.sub = 1'b0;
        case (i_op)
            OP_SUM_CARRY:      arith.cin = flags_r[FLAG_C];
            OP_DIFF:           arith.sub = 1'b1;
            OP_DIFF_BORROW:
            begin
                arith.sub = 1'b1;
                arith.cin = flags_r[FLAG_C];
            end
            OP_DIFF_IMM:
            begin
                arith.sub = 1'b1;
                arith.b   = i_imm;
            end
            OP_DIFF_CARRY_IMM:
            begin
                arith.sub = 1'b1;
                arith.b   = i_imm;
                arith.cin = flags_r[FLAG_C];
            end
            OP_INVERT:
            begin
                arith.sub = 1'b1;
                arith.a   = BYTE_ONES;
                arith.b   = i_dest;
            end
            OP_SIGN_FLIP:
            begin
                arith.sub = 1'b1;
                arith.a   = BYTE_ZERO;
                arith.b   = i_dest;
            end
            default:           arith.b = i_src;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte result and flag selection
    always_comb
    begin
        res_nxt  = i_dest;
        wr_nxt   = 1'b1;
        logic_op = 1'b0;
        arith_op = 1'b0;
        case (i_op)
            OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_DIFF_IMM, OP_DIFF_BORROW,
            OP_DIFF_CARRY_IMM, OP_SIGN_FLIP, OP_INVERT:
            begin
                res_nxt  = arith.res;
                arith_op = 1'b1;
            end
            OP_CONJ:           res_nxt = i_dest & i_src;
            OP_CONJ_IMM:       res_nxt = i_dest & i_imm;
            OP_DISJ:           res_nxt = i_dest | i_src;
            OP_DISJ_IMM:       res_nxt = i_dest | i_imm;
            OP_EXCL_DISJ:      res_nxt = i_dest ^ i_src;
            OP_BIT_SET_MASK:   res_nxt = i_dest | i_imm;
            OP_BIT_CLEAR_MASK: res_nxt = i_dest & (BYTE_ONES - i_imm);
            OP_ZERO_SIGN_TEST: res_nxt = i_dest & i_dest;
            OP_ZERO_REG:       res_nxt = i_dest ^ i_dest;
            OP_PLUS_ONE:       res_nxt = i_dest + BYTE_ONE;
            OP_MINUS_ONE:      res_nxt = i_dest - BYTE_ONE;
            OP_ALL_ONES:       res_nxt = BYTE_ONES;
            default:           wr_nxt  = 1'b0;
        endcase
        logic_op = wr_nxt && !arith_op && (i_op != OP_ALL_ONES);

        flags_nxt = flags_r;
        if (arith_op || logic_op)
        begin
            flags_nxt[FLAG_Z] = (res_nxt == BYTE_ZERO);
            flags_nxt[FLAG_N] = res_nxt[DATA_W-1];
        end
        if (logic_op)
        begin
            flags_nxt[FLAG_V] = 1'b0;
            if (i_op == OP_PLUS_ONE)
                flags_nxt[FLAG_V] = (res_nxt == OVF_INC);
            if (i_op == OP_MINUS_ONE)
                flags_nxt[FLAG_V] = (res_nxt == OVF_DEC);
        end
        if (arith_op)
        begin
            flags_nxt[FLAG_C] = arith.cout;
            flags_nxt[FLAG_V] = arith.ovf;
            flags_nxt[FLAG_H] = arith.half;
            if (i_op == OP_INVERT)
            begin
                flags_nxt[FLAG_C] = 1'b1;
                flags_nxt[FLAG_V] = 1'b0;
                flags_nxt[FLAG_H] = flags_r[FLAG_H];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word result and flags from latched pair
    always_comb
    begin
        if (wsub_r)
            wres = {whi_r, wlo_r} - {10'h000, wimm_r};
        else
            wres = {whi_r, wlo_r} + {10'h000, wimm_r};
        wvf = wsub_r ? (whi_r[7] && !wres[15]) : (!whi_r[7] && wres[15]);
        wcf = wsub_r ? (wres[15] && !whi_r[7]) : (!wres[15] && whi_r[7]);
        wflags         = flags_r;
        wflags[FLAG_Z] = (wres == 16'h0000);
        wflags[FLAG_N] = wres[WORD_W-1];
        wflags[FLAG_V] = wvf;
        wflags[FLAG_C] = wcf;
        wflags[FLAG_S] = wres[WORD_W-1] ^ wvf;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer for two-cycle word ops
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            state_r <= ST_IDLE;
        else if (state_r == ST_WORD_HI)
            state_r <= ST_IDLE;
        else if (take && word_req)
            state_r <= ST_WORD_HI;
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wlo_r   <= BYTE_ZERO;
            whi_r   <= BYTE_ZERO;
            wimm_r  <= 6'h00;
            wsub_r  <= 1'b0;
            wpair_r <= 2'h0;
        end
        else if (take && word_req)
        begin
            wlo_r   <= i_pair_lo;
            whi_r   <= i_pair_hi;
            wimm_r  <= i_imm[WIMM_W-1:0];
            wsub_r  <= (i_op == OP_WORD_MINUS_IMM);
            wpair_r <= i_pair_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            flags_r <= FLAGS_RESET;
        else if (state_r == ST_WORD_HI)
            flags_r <= wflags;
        else if (take && !word_req)
            flags_r <= flags_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-back outputs
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            result_r     <= BYTE_ZERO;
            result_hi_r  <= BYTE_ZERO;
            write_r      <= 1'b0;
            write_word_r <= 1'b0;
            pair_r       <= 2'h0;
        end
        else if (state_r == ST_WORD_HI)
        begin
            result_r     <= wres[DATA_W-1:0];
            result_hi_r  <= wres[WORD_W-1:DATA_W];
            write_r      <= 1'b0;
            write_word_r <= 1'b1;
            pair_r       <= wpair_r;
        end
        else
        begin
            result_r     <= res_nxt;
            write_r      <= take && !word_req && wr_nxt;
            write_word_r <= 1'b0;
        end
    end

    assign o_result     = result_r;
    assign o_result_hi  = result_hi_r;
    assign o_write      = write_r;
    assign o_write_word = write_word_r;
    assign o_pair_sel   = pair_r;
    assign o_flags      = flags_r;
    assign o_busy       = (state_r == ST_WORD_HI);

endmodule

`default_nettype wire

// [dv/alu_core_props.sv]
`timescale 1ns/1ps
`default_nettype none

module alu_core_props
(
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_valid,
    input  wire alu_pkg::op_t               i_op,
    input  wire logic [alu_pkg::DATA_W-1:0] o_result,
    input  wire logic [alu_pkg::DATA_W-1:0] o_result_hi,
    input  wire logic                       o_write,
    input  wire logic                       o_write_word,
    input  wire logic [alu_pkg::DATA_W-1:0] o_flags,
    input  wire logic                       o_busy
);
    import alu_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    logic take;
    logic word;
    assign take = i_valid && !o_busy;
    assign word = i_op inside {OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM};

    sequence busy_step;
        o_busy && !o_write_word;
    endsequence
    sequence word_done;
        !o_busy && o_write_word && !o_write;
    endsequence

    a_word_two_steps:
        assert property (take && word |=> busy_step ##1 word_done) else $error("word timing");
    a_byte_one_step:
        assert property (take && !word |=> o_write && !o_busy) else $error("byte timing");
    a_busy_single:
        assert property (o_busy |=> !o_busy) else $error("busy too long");
    a_refuse_busy:
        assert property (o_busy |=> !o_write) else $error("write after busy");
    a_ones_no_flags:
        assert property (take && i_op == OP_ALL_ONES |=> o_result == BYTE_ONES && $stable(o_flags))
        else $error("all ones load");
    a_step_keeps_carry:
        assert property (take && i_op inside {OP_PLUS_ONE, OP_MINUS_ONE}
            |=> $stable(o_flags[FLAG_C])) else $error("carry changed");
    a_byte_zero_sign:
        assert property (o_write && $past(i_op) != OP_ALL_ONES |-> o_flags[FLAG_Z] ==
            (o_result == BYTE_ZERO) && o_flags[FLAG_N] == o_result[7]) else $error("byte Z N");
    a_word_flag_set:
        assert property (o_write_word |-> o_flags[FLAG_S] == (o_flags[FLAG_N] ^ o_flags[FLAG_V])
            && o_flags[FLAG_N] == o_result_hi[7]) else $error("word S N");
    a_spare_flags:
        assert property (o_flags[7:6] == 2'h0) else $error("spare flag set");
endmodule

bind alu_core alu_core_props u_props
(
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_valid     (i_valid),
    .i_op        (i_op),
    .o_result    (o_result),
    .o_result_hi (o_result_hi),
    .o_write     (o_write),
    .o_write_word(o_write_word),
    .o_flags     (o_flags),
    .o_busy      (o_busy)
);

`default_nettype wire

// [dv/reg_file_model.sv]
`timescale 1ns/1ps
`default_nettype none

module reg_file_model
(
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_load,
    input  wire logic [alu_pkg::WORD_W-1:0] i_load_val,
    input  wire logic                       i_write,
    input  wire logic                       i_write_word,
    input  wire logic [alu_pkg::DATA_W-1:0] i_lo,
    input  wire logic [alu_pkg::DATA_W-1:0] i_hi,
    output logic      [alu_pkg::DATA_W-1:0] o_dest,
    output logic      [alu_pkg::WORD_W-1:0] o_pair
);
    import alu_pkg::*;

    // Preload and write back
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_dest <= 8'h00;
            o_pair <= 16'h0000;
        end
        else if (i_load)
        begin
            o_dest <= i_load_val[7:0];
            o_pair <= i_load_val;
        end
        else
        begin
            if (i_write)
                o_dest <= i_lo;
            if (i_write_word)
                o_pair <= {i_hi, i_lo};
        end
    end
endmodule

`default_nettype wire

// [dv/alu_core_test.sv]
`timescale 1ns/1ps
`default_nettype none

module alu_core_test;
    import alu_pkg::*;
    logic        i_clk;
    logic        i_reset;
    logic        i_valid;
    logic        load;
    op_t         i_op;
    logic [7:0]  i_src;
    logic [7:0]  i_imm;
    logic [1:0]  i_pair_sel;
    logic [15:0] load_val;
    logic [7:0]  dest;
    logic [15:0] pair;
    logic [7:0]  o_result;
    logic [7:0]  o_result_hi;
    logic        o_write;
    logic        o_write_word;
    logic [1:0]  o_pair_sel;
    logic [7:0]  o_flags;
    logic        o_busy;
    int          errors;
    int          comparisons;

    alu_core dut (.i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid), .i_op(i_op),
        .i_dest(dest), .i_src(i_src), .i_imm(i_imm), .i_pair_sel(i_pair_sel),
        .i_pair_lo(pair[7:0]), .i_pair_hi(pair[15:8]), .o_result(o_result),
        .o_result_hi(o_result_hi), .o_write(o_write), .o_write_word(o_write_word),
        .o_pair_sel(o_pair_sel), .o_flags(o_flags), .o_busy(o_busy));
    reg_file_model regs (.i_clk(i_clk), .i_reset(i_reset), .i_load(load),
        .i_load_val(load_val), .i_write(o_write), .i_write_word(o_write_word),
        .i_lo(o_result), .i_hi(o_result_hi), .o_dest(dest), .o_pair(pair));

    always #25 i_clk = ~i_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Shared operation driver
    task automatic do_op(input op_t op, input logic [15:0] v, input logic [7:0] k,
        input logic [15:0] er, input logic [7:0] ef);
        logic w;
        w = op inside {OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM};
        @(posedge i_clk);
        load <= 1'b1;
        load_val <= v;
        @(posedge i_clk);
        load <= 1'b0;
        i_valid <= 1'b1;
        i_op <= op;
        i_src <= k;
        i_imm <= k;
        i_pair_sel <= i_pair_sel + 2'h1;
        @(posedge i_clk);
        if (w)
            i_op <= OP_SUM;
        else
            i_valid <= 1'b0;
        #1;
        chk(16'(o_busy), 16'(w));
        if (w)
        begin
            @(posedge i_clk);
            i_valid <= 1'b0;
            #1;
            chk(16'(o_write_word), 16'h0001);
            chk(16'(o_result_hi), 16'(er[15:8]));
            chk(16'(o_pair_sel), 16'(i_pair_sel));
        end
        chk(16'(o_write), 16'(!w));
        chk(16'(o_result), 16'(er[7:0]));
        chk(16'(o_flags), 16'(ef));
        @(posedge i_clk);
        #1;
        chk(16'(o_write), 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic arith_chain;
        do_op(OP_SUM, 16'h000F, 8'h01, 16'h0010, 8'h20);
        do_op(OP_SUM, 16'h00FF, 8'h01, 16'h0000, 8'h23);
        do_op(OP_SUM_CARRY, 16'h007F, 8'h00, 16'h0080, 8'h2C);
        do_op(OP_DIFF, 16'h0000, 8'h01, 16'h00FF, 8'h25);
        do_op(OP_DIFF_BORROW, 16'h0010, 8'h20, 16'h00EF, 8'h25);
        do_op(OP_DIFF_CARRY_IMM, 16'h0012, 8'h0F, 16'h0002, 8'h20);
        do_op(OP_DIFF_BORROW, 16'h0005, 8'h02, 16'h0003, 8'h00);
        do_op(OP_DIFF_IMM, 16'h0080, 8'h01, 16'h007F, 8'h28);
    endtask

    task automatic logic_chain;
        do_op(OP_CONJ, 16'h00F0, 8'h3C, 16'h0030, 8'h20);
        do_op(OP_CONJ_IMM, 16'h000F, 8'hF0, 16'h0000, 8'h22);
        do_op(OP_DISJ, 16'h0080, 8'h01, 16'h0081, 8'h24);
        do_op(OP_DISJ_IMM, 16'h0000, 8'h00, 16'h0000, 8'h22);
        do_op(OP_EXCL_DISJ, 16'h00FF, 8'h0F, 16'h00F0, 8'h24);
        do_op(OP_BIT_SET_MASK, 16'h0001, 8'h80, 16'h0081, 8'h24);
        do_op(OP_BIT_CLEAR_MASK, 16'h0081, 8'h80, 16'h0001, 8'h20);
        do_op(OP_ZERO_SIGN_TEST, 16'h0080, 8'h00, 16'h0080, 8'h24);
        do_op(OP_ZERO_REG, 16'h005A, 8'h00, 16'h0000, 8'h22);
        do_op(OP_ALL_ONES, 16'h0000, 8'h00, 16'h00FF, 8'h22);
    endtask

    task automatic mid_reset;
        @(posedge i_clk);
        i_reset <= 1'b1;
        @(posedge i_clk);
        #1;
        chk(16'(o_flags), 16'h0000);
        chk(16'(o_result), 16'h0000);
        @(posedge i_clk);
        i_reset <= 1'b0;
    endtask

    task automatic unary_chain;
        do_op(OP_INVERT, 16'h000F, 8'h00, 16'h00F0, 8'h05);
        do_op(OP_SIGN_FLIP, 16'h0080, 8'h00, 16'h0080, 8'h0D);
        do_op(OP_PLUS_ONE, 16'h00FF, 8'h00, 16'h0000, 8'h03);
        do_op(OP_MINUS_ONE, 16'h0080, 8'h00, 16'h007F, 8'h09);
    endtask

    task automatic word_ops;
        do_op(OP_WORD_PLUS_IMM, 16'h00FF, 8'h01, 16'h0100, 8'h00);
        do_op(OP_WORD_PLUS_IMM, 16'h7FFF, 8'h3F, 16'h803E, 8'h0C);
        do_op(OP_WORD_MINUS_IMM, 16'h0000, 8'h01, 16'hFFFF, 8'h15);
        do_op(OP_WORD_MINUS_IMM, 16'h0005, 8'h45, 16'h0000, 8'h02);
    endtask

    // Two byte ops on consecutive edges, carry handed on
    task automatic back_to_back;
        @(posedge i_clk);
        load <= 1'b1;
        load_val <= 16'h00F0;
        @(posedge i_clk);
        load <= 1'b0;
        i_valid <= 1'b1;
        i_op <= OP_SUM;
        i_src <= 8'h20;
        @(posedge i_clk);
        i_op <= OP_SUM_CARRY;
        i_src <= 8'h01;
        #1;
        chk(16'(o_result), 16'h0010);
        chk(16'(o_flags), 16'h0001);
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
        chk(16'(o_write), 16'h0001);
        chk(16'(o_result), 16'h00F2);
        chk(16'(o_flags), 16'h0004);
    endtask

    initial
    begin
        repeat (2000) @(posedge i_clk);
        errors++;
        final_report();
    end

    initial
    begin
        i_clk = 1'b0;
        i_reset = 1'b1;
        i_valid = 1'b0;
        load = 1'b0;
        load_val = 16'h0000;
        i_op = OP_SUM;
        i_src = 8'h00;
        i_imm = 8'h00;
        i_pair_sel = 2'h0;
        errors = 0;
        comparisons = 0;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        arith_chain();
        logic_chain();
        mid_reset();
        unary_chain();
        word_ops();
        back_to_back();
        final_report();
    end
endmodule

`default_nettype wire
